// ===== include/uc_pkg.sv
// uc_pkg: shared constants and types of the serial controller
// How it works
// - clock_out: oscillator or baud clock per bit 7
// - baud clock is sixteen ticks per bit
// - divisor zero divides the input by one
// - idle transmitter starts on fifth tick after write
// - idle transmitter: holding empty on fourth tick
// - chained character starts after sixteenth stop tick
// - chained: holding empty after fifteenth stop tick
// - clear-to-send high holds; fourth/fifth ticks after low
// - status bit 6 follows holding empty
// - eleventh stop tick sets transmit complete, irq
// - eleventh stop tick updates receive error flags
// - eleventh stop tick sets data ready
// - modem line change sets flag, gated irq
// - rts and dtr change as write ends
package uc_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 2;
	localparam int DIV_W = 7;
	localparam int FRAME_W = 11;
	localparam int FIFO_DEPTH = 8;
	// pin bundle: data, addr, rd_n, wr_n, cts_n, dsr_n, serial_in
	localparam int PIN_W = DATA_W + ADDR_W + 5;
	localparam logic [PIN_W-1:0] PIN_RST = 15'h001F;
	// register addresses
	localparam logic [ADDR_W-1:0] A_DATA = 2'h0;
	localparam logic [ADDR_W-1:0] A_BAUD = 2'h1;
	localparam logic [ADDR_W-1:0] A_CTRL = 2'h2;
	localparam logic [ADDR_W-1:0] A_STAT = 2'h3;
	localparam logic [DATA_W-1:0] BAUD_RST = 8'h00;
	localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
	localparam int BAUD_CLK_SEL = 7;
	// control bits
	localparam int CT_IRQ_EN = 0;
	localparam int CT_MODEM_EN = 1;
	localparam int CT_RTS = 2;
	localparam int CT_DTR = 3;
	localparam int CT_PAR_EN = 4;
	// line_status bits
	localparam int ST_DR = 7;
	localparam int ST_THE = 6;
	localparam int ST_TXC = 5;
	localparam int ST_MODEM = 4;
	localparam int ST_OVR = 3;
	localparam int ST_FRM = 2;
	localparam int ST_PAR = 1;
	localparam int ST_BRK = 0;
	// tick positions, counted from zero
	localparam logic [2:0] ARM_THE_IDX = 3'h3;
	localparam logic [2:0] ARM_START_IDX = 3'h4;
	localparam logic [3:0] STOP_TXC = 4'hA;
	localparam logic [3:0] STOP_CHAIN = 4'hB;
	localparam logic [3:0] STOP_THE = 4'hE;
	localparam logic [3:0] STOP_LAST = 4'hF;
	localparam logic [3:0] RX_MID = 4'h7;
	localparam logic [3:0] RX_DONE = 4'hA;
	localparam logic [3:0] BITS_PLAIN = 4'hA;
	localparam logic [3:0] BITS_PAR = 4'hB;
	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_ARM = 2'b01, TX_SEND = 2'b10} uc_tx_st_t;
	typedef enum logic {RX_IDLE = 1'b0, RX_RUN = 1'b1} uc_rx_st_t;
endpackage : uc_pkg

// ===== src/uc_fifo.sv
// uc_fifo: flop-based fifo for received characters
module uc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wp_reg;
	logic [AW-1:0]    rp_reg;
	logic [AW:0]      cnt_reg;
	logic             push;
	logic             pop;
	assign in_ready = cnt_reg != (AW+1)'(DEPTH);
	assign out_valid = cnt_reg != '0;
	assign out_data = mem_reg[rp_reg];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wp_reg] <= in_data;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wp_reg <= (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'h1;
			end
			if (pop) begin
				rp_reg <= (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'h1;
			end
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : uc_fifo

// ===== src/uc_top.sv
// uc_top: serial controller with baud generator, bus port and modem lines
module uc_top (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      sys_rst,
	// processor bus
	input  wire logic [uc_pkg::ADDR_W-1:0] addr,
	input  wire logic                      rd_n,
	input  wire logic                      wr_n,
	input  wire logic [uc_pkg::DATA_W-1:0] data_in,
	output logic      [uc_pkg::DATA_W-1:0] data_out,
	output logic                           data_oe,
	output logic                           irq_out,
	// serial line and modem
	input  wire logic                      serial_in,
	output logic                           serial_out,
	input  wire logic                      cts_n,
	input  wire logic                      dsr_n,
	output logic                           rts_n,
	output logic                           dtr_n,
	// clock output
	output logic                           clock_out
);
	localparam int DW = uc_pkg::DATA_W;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// pin synchronisers
	logic [uc_pkg::PIN_W-1:0]  pin_s1_reg;
	logic [uc_pkg::PIN_W-1:0]  pin_s2_reg;
	logic [DW-1:0]             s_din;
	logic [uc_pkg::ADDR_W-1:0] s_addr;
	logic                      s_rd_n;
	logic                      s_wr_n;
	logic                      s_cts_n;
	logic                      s_dsr_n;
	logic                      s_rxd;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_s1_reg <= uc_pkg::PIN_RST;
			pin_s2_reg <= uc_pkg::PIN_RST;
		end else begin
			pin_s1_reg <= {data_in, addr, rd_n, wr_n, cts_n, dsr_n, serial_in};
			pin_s2_reg <= pin_s1_reg;
		end
	end
	assign {s_din, s_addr, s_rd_n, s_wr_n, s_cts_n, s_dsr_n, s_rxd} = pin_s2_reg;

	// strobe and modem edges
	logic rd_q_reg;
	logic wr_q_reg;
	logic cts_q_reg;
	logic dsr_q_reg;
	logic rd_fall;
	logic wr_fall;
	logic wr_rise;
	logic modem_ev;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_q_reg <= 1'h1;
			wr_q_reg <= 1'h1;
			cts_q_reg <= 1'h1;
			dsr_q_reg <= 1'h1;
		end else begin
			rd_q_reg <= s_rd_n;
			wr_q_reg <= s_wr_n;
			cts_q_reg <= s_cts_n;
			dsr_q_reg <= s_dsr_n;
		end
	end
	assign rd_fall = rd_q_reg & ~s_rd_n;
	assign wr_fall = wr_q_reg & ~s_wr_n;
	assign wr_rise = ~wr_q_reg & s_wr_n;
	assign modem_ev = (s_cts_n ^ cts_q_reg) | (s_dsr_n ^ dsr_q_reg);

	// write capture; data is taken while the strobe is low, committed as it rises
	logic [DW-1:0]             wd_reg;
	logic [uc_pkg::ADDR_W-1:0] wa_reg;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wd_reg <= '0;
			wa_reg <= '0;
		end else if (!s_wr_n) begin
			wd_reg <= s_din;
			wa_reg <= s_addr;
		end
	end

	// configuration registers
	logic [DW-1:0] baud_select_reg;
	logic [DW-1:0] ctrl_reg;
	logic          rts_n_reg;
	logic          dtr_n_reg;
	logic          par_en;
	logic          irq_en;
	logic          modem_irq_enable;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			baud_select_reg <= uc_pkg::BAUD_RST;
			ctrl_reg <= uc_pkg::CTRL_RST;
		end else if (wr_rise) begin
			if (wa_reg == uc_pkg::A_BAUD) begin
				baud_select_reg <= wd_reg;
			end
			if (wa_reg == uc_pkg::A_CTRL) begin
				ctrl_reg <= wd_reg;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rts_n_reg <= 1'h1;
			dtr_n_reg <= 1'h1;
		end else if (wr_rise && wa_reg == uc_pkg::A_CTRL) begin
			rts_n_reg <= ~wd_reg[uc_pkg::CT_RTS];
			dtr_n_reg <= ~wd_reg[uc_pkg::CT_DTR];
		end
	end
	assign par_en = ctrl_reg[uc_pkg::CT_PAR_EN];
	assign irq_en = ctrl_reg[uc_pkg::CT_IRQ_EN];
	assign modem_irq_enable = ctrl_reg[uc_pkg::CT_MODEM_EN];

	// baud generator: one tick per falling edge of the 16x clock
	logic [uc_pkg::DIV_W-1:0] div_cnt_reg;
	logic                     tick;
	logic                     clock_out_reg;
	// compare by >= so a smaller divisor written mid-count takes effect at once
	assign tick = div_cnt_reg >= baud_select_reg[uc_pkg::DIV_W-1:0];
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			div_cnt_reg <= '0;
		end else begin
			div_cnt_reg <= tick ? '0 : div_cnt_reg + 1'h1;
		end
	end
	// with bit 7 set, divide by one leaves clock_out low: a flop cannot show clk itself
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			clock_out_reg <= 1'h0;
		end else if (baud_select_reg[uc_pkg::BAUD_CLK_SEL]) begin
			clock_out_reg <= ~tick;
		end else begin
			clock_out_reg <= ~clock_out_reg;
		end
	end

	// transmitter
	function automatic logic [uc_pkg::FRAME_W-1:0] frame(input logic [DW-1:0] d, input logic p);
		frame = p ? {1'h1, ^d, d, 1'h0} : {2'h3, d, 1'h0};
	endfunction : frame
	uc_pkg::uc_tx_st_t          tx_st_reg;
	logic [2:0]                 arm_cnt_reg;
	logic [3:0]                 tx_bit_reg;
	logic [3:0]                 tx_sub_reg;
	logic [uc_pkg::FRAME_W-1:0] tx_shift_reg;
	logic [DW-1:0]              tx_holding_reg;
	logic                       tx_holding_empty_reg;
	logic                       chain_reg;
	logic                       serial_out_reg;
	logic [3:0]                 last_idx;
	logic                       tx_gate;
	logic                       arm_the;
	logic                       arm_start;
	logic                       tx_last;
	logic                       stop_txc;
	logic                       stop_chain;
	logic                       stop_the;
	logic                       stop_end;
	logic                       tx_load;
	assign last_idx = (par_en ? uc_pkg::BITS_PAR : uc_pkg::BITS_PLAIN) - 4'h1;
	// clear-to-send high or a write still in progress restarts the count, until the fourth tick
	assign tx_gate = (~s_cts_n & s_wr_n) | (arm_cnt_reg > uc_pkg::ARM_THE_IDX);
	assign arm_the = tx_st_reg == uc_pkg::TX_ARM && tick && tx_gate
		&& arm_cnt_reg == uc_pkg::ARM_THE_IDX;
	assign arm_start = tx_st_reg == uc_pkg::TX_ARM && tick && tx_gate
		&& arm_cnt_reg == uc_pkg::ARM_START_IDX;
	assign tx_last = tx_st_reg == uc_pkg::TX_SEND && tx_bit_reg == last_idx;
	assign stop_txc = tx_last && tick && tx_sub_reg == uc_pkg::STOP_TXC;
	assign stop_chain = tx_last && tick && tx_sub_reg == uc_pkg::STOP_CHAIN;
	assign stop_the = tx_last && tick && tx_sub_reg == uc_pkg::STOP_THE && chain_reg;
	assign stop_end = tx_last && tick && tx_sub_reg == uc_pkg::STOP_LAST;
	assign tx_load = arm_the | stop_the;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_st_reg <= uc_pkg::TX_IDLE;
			arm_cnt_reg <= '0;
			tx_bit_reg <= '0;
			tx_sub_reg <= '0;
			chain_reg <= 1'h0;
			serial_out_reg <= 1'h1;
		end else begin
			unique case (tx_st_reg)
				uc_pkg::TX_IDLE: begin
					arm_cnt_reg <= '0;
					if (!tx_holding_empty_reg) begin
						tx_st_reg <= uc_pkg::TX_ARM;
					end
				end
				uc_pkg::TX_ARM: begin
					if (!tx_gate) begin
						arm_cnt_reg <= '0;
					end else if (tick) begin
						arm_cnt_reg <= arm_cnt_reg + 3'h1;
					end
					if (arm_start) begin
						tx_st_reg <= uc_pkg::TX_SEND;
						serial_out_reg <= 1'h0;
						tx_bit_reg <= '0;
						tx_sub_reg <= '0;
					end
				end
				uc_pkg::TX_SEND: if (tick) begin
					tx_sub_reg <= tx_sub_reg + 4'h1;
					if (stop_chain) begin
						chain_reg <= ~tx_holding_empty_reg & ~s_cts_n & s_wr_n;
					end
					if (stop_end) begin
						tx_bit_reg <= '0;
						if (chain_reg) begin
							serial_out_reg <= 1'h0;
						end else begin
							tx_st_reg <= uc_pkg::TX_IDLE;
						end
					end else if (tx_sub_reg == uc_pkg::STOP_LAST) begin
						tx_bit_reg <= tx_bit_reg + 4'h1;
						serial_out_reg <= tx_shift_reg[tx_bit_reg + 4'h1];
					end
				end
				default: tx_st_reg <= uc_pkg::TX_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_shift_reg <= '1;
		end else if (tx_load) begin
			tx_shift_reg <= frame(tx_holding_reg, par_en);
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_holding_reg <= '0;
		end else if (wr_rise && wa_reg == uc_pkg::A_DATA) begin
			tx_holding_reg <= wd_reg;
		end
	end
	// a new write wins over a transfer in the same cycle, else data is lost
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_holding_empty_reg <= 1'h1;
		end else if (wr_fall && s_addr == uc_pkg::A_DATA) begin
			tx_holding_empty_reg <= 1'h0;
		end else if (tx_load) begin
			tx_holding_empty_reg <= 1'h1;
		end
	end

	// receiver
	uc_pkg::uc_rx_st_t          rx_st_reg;
	logic [uc_pkg::FRAME_W-1:0] rx_bits_reg;
	logic [3:0]                 rx_bit_reg;
	logic [3:0]                 rx_sub_reg;
	logic                       rx_done;
	logic                       rx_ovr;
	logic                       rx_frm;
	logic                       rx_par;
	logic                       rx_brk;
	logic                       rx_err;
	logic                       fifo_in_ready;
	logic                       rx_data_ready;
	logic                       rx_pop;
	logic [DW-1:0]              rx_buffer_word;
	assign rx_done = rx_st_reg == uc_pkg::RX_RUN && tick && rx_bit_reg == last_idx
		&& rx_sub_reg == uc_pkg::RX_DONE;
	assign rx_frm = ~rx_bits_reg[last_idx];
	assign rx_par = par_en & ^rx_bits_reg[uc_pkg::FRAME_W-2:1];
	assign rx_brk = ~|rx_bits_reg;
	assign rx_ovr = ~fifo_in_ready;
	assign rx_err = rx_ovr | rx_frm | rx_par | rx_brk;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_st_reg <= uc_pkg::RX_IDLE;
			rx_bits_reg <= '0;
			rx_bit_reg <= '0;
			rx_sub_reg <= '0;
		end else begin
			unique case (rx_st_reg)
				uc_pkg::RX_IDLE: if (tick && !s_rxd) begin
					rx_st_reg <= uc_pkg::RX_RUN;
					rx_bits_reg <= '0;
					rx_bit_reg <= '0;
					rx_sub_reg <= '0;
				end
				uc_pkg::RX_RUN: if (tick) begin
					rx_sub_reg <= rx_sub_reg + 4'h1;
					if (rx_sub_reg == uc_pkg::RX_MID) begin
						rx_bits_reg[rx_bit_reg] <= s_rxd;
						// a start bit gone high by mid-bit was a glitch
						if (rx_bit_reg == '0 && s_rxd) begin
							rx_st_reg <= uc_pkg::RX_IDLE;
						end
					end
					// leaving early lets the next start edge be caught
					if (rx_done) begin
						rx_st_reg <= uc_pkg::RX_IDLE;
					end else if (rx_sub_reg == uc_pkg::STOP_LAST) begin
						rx_bit_reg <= rx_bit_reg + 4'h1;
					end
				end
			endcase
		end
	end
	assign rx_pop = rd_fall && s_addr == uc_pkg::A_DATA;
	uc_fifo #(
		.WIDTH(DW),
		.DEPTH(uc_pkg::FIFO_DEPTH)
	) u_rx_fifo (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.in_valid (rx_done),
		.in_ready (fifo_in_ready),
		.in_data  (rx_bits_reg[DW:1]),
		.out_valid(rx_data_ready),
		.out_ready(rx_pop),
		.out_data (rx_buffer_word)
	);

	// status flags; a set wins over the clearing status read
	logic tx_complete_reg;
	logic modem_change_reg;
	logic overrun_reg;
	logic framing_err_reg;
	logic parity_err_reg;
	logic rx_break_reg;
	logic stat_rd;
	assign stat_rd = rd_fall && s_addr == uc_pkg::A_STAT;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_complete_reg <= 1'h0;
			modem_change_reg <= 1'h0;
			overrun_reg <= 1'h0;
			framing_err_reg <= 1'h0;
			parity_err_reg <= 1'h0;
			rx_break_reg <= 1'h0;
		end else begin
			if (stop_txc && tx_holding_empty_reg) begin
				tx_complete_reg <= 1'h1;
			end else if (stat_rd) begin
				tx_complete_reg <= 1'h0;
			end
			if (modem_ev) begin
				modem_change_reg <= 1'h1;
			end else if (stat_rd) begin
				modem_change_reg <= 1'h0;
			end
			if (rx_done && rx_ovr) begin
				overrun_reg <= 1'h1;
			end else if (stat_rd) begin
				overrun_reg <= 1'h0;
			end
			if (rx_done && rx_frm) begin
				framing_err_reg <= 1'h1;
			end else if (stat_rd) begin
				framing_err_reg <= 1'h0;
			end
			if (rx_done && rx_par) begin
				parity_err_reg <= 1'h1;
			end else if (stat_rd) begin
				parity_err_reg <= 1'h0;
			end
			if (rx_done && rx_brk) begin
				rx_break_reg <= 1'h1;
			end else if (stat_rd) begin
				rx_break_reg <= 1'h0;
			end
		end
	end
	logic [DW-1:0] line_status;
	always_comb begin
		line_status = '0;
		line_status[uc_pkg::ST_DR] = rx_data_ready;
		line_status[uc_pkg::ST_THE] = tx_holding_empty_reg;
		line_status[uc_pkg::ST_TXC] = tx_complete_reg;
		line_status[uc_pkg::ST_MODEM] = modem_change_reg;
		line_status[uc_pkg::ST_OVR] = overrun_reg;
		line_status[uc_pkg::ST_FRM] = framing_err_reg;
		line_status[uc_pkg::ST_PAR] = parity_err_reg;
		line_status[uc_pkg::ST_BRK] = rx_break_reg;
	end

	// interrupt: set wins over the clearing read
	logic irq_out_reg;
	logic irq_set;
	assign irq_set = (irq_en & ((stop_txc & tx_holding_empty_reg) | (rx_done & rx_err)))
		| (irq_en & modem_irq_enable & modem_ev);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_out_reg <= 1'h0;
		end else if (irq_set) begin
			irq_out_reg <= 1'h1;
		end else if (rd_fall) begin
			irq_out_reg <= 1'h0;
		end
	end

	// read port
	logic [DW-1:0] data_out_reg;
	logic          data_oe_reg;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			data_out_reg <= '0;
			data_oe_reg <= 1'h0;
		end else begin
			data_oe_reg <= ~s_rd_n;
			if (rd_fall) begin
				unique case (s_addr)
					uc_pkg::A_DATA: data_out_reg <= rx_buffer_word;
					uc_pkg::A_BAUD: data_out_reg <= baud_select_reg;
					uc_pkg::A_CTRL: data_out_reg <= ctrl_reg;
					uc_pkg::A_STAT: data_out_reg <= line_status;
				endcase
			end
		end
	end

	assign data_out = data_out_reg;
	assign data_oe = data_oe_reg;
	assign irq_out = irq_out_reg;
	assign serial_out = serial_out_reg;
	assign rts_n = rts_n_reg;
	assign dtr_n = dtr_n_reg;
	assign clock_out = clock_out_reg;

	sequence s_arm_fourth;
		arm_the && !wr_fall;
	endsequence
	sequence s_arm_fifth;
		arm_start;
	endsequence
	sequence s_chain_armed;
		stop_chain && !tx_holding_empty_reg && !s_cts_n && s_wr_n;
	endsequence
	AST_THE_4TH: assert property (s_arm_fourth |=> tx_holding_empty_reg)
		else $error("holding empty not raised on fourth tick");
	AST_START_5TH: assert property (s_arm_fifth |=> !serial_out_reg && tx_st_reg == uc_pkg::TX_SEND)
		else $error("start bit not sent on fifth tick");
	AST_CTS_HOLD: assert property (tx_st_reg == uc_pkg::TX_ARM && s_cts_n && !tx_holding_empty_reg
		|=> serial_out_reg && !tx_holding_empty_reg)
		else $error("transmit not held by clear-to-send");
	AST_CHAIN_START: assert property (stop_end && chain_reg |=> !serial_out_reg && tx_bit_reg == '0)
		else $error("chained character did not start");
	AST_CHAIN_THE: assert property (s_chain_armed |-> ##[1:400] tx_holding_empty_reg)
		else $error("holding empty not raised for chained character");
	AST_TXC_11TH: assert property (stop_txc && tx_holding_empty_reg |=> tx_complete_reg)
		else $error("transmit complete not set");
	AST_OVR_11TH: assert property (rx_done && rx_ovr |=> overrun_reg)
		else $error("overrun not flagged");
	AST_DR_11TH: assert property (rx_done && fifo_in_ready |=> rx_data_ready)
		else $error("data ready not set");
	AST_MODEM: assert property (modem_ev && irq_en && modem_irq_enable
		|=> modem_change_reg && irq_out_reg)
		else $error("modem change not flagged");
	AST_RD_IRQ: assert property (rd_fall && !irq_set |=> !irq_out_reg)
		else $error("read did not drop irq");
	AST_RTS: assert property (wr_rise && wa_reg == uc_pkg::A_CTRL
		|=> rts_n_reg != wd_reg[uc_pkg::CT_RTS])
		else $error("rts did not follow write");
	AST_CLK_OSC: assert property (!baud_select_reg[uc_pkg::BAUD_CLK_SEL]
		##1 !baud_select_reg[uc_pkg::BAUD_CLK_SEL] |-> clock_out_reg != $past(clock_out_reg))
		else $error("clock_out not toggling in oscillator mode");
endmodule : uc_top

// ===== test/uc_far_end.sv
// uc_far_end: remote serial device, sends frames and decodes frames
module uc_far_end #(
	parameter int BIT_CLK = 16
) (
	// clock
	input  wire logic clk,
	// serial lines
	input  wire logic line_rx,
	output logic      line_tx
);
	logic [7:0] got[$];
	logic [7:0] sh;
	time        t_start;
	initial line_tx = 1'b1;
	// start, eight bits lsb first, one stop; idle line rests high
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_tx <= f[i];
			repeat (BIT_CLK) @(posedge clk);
		end
	endtask : send
	// sample mid-bit so a short low glitch is dropped
	always begin
		@(negedge line_rx);
		t_start = $time;
		repeat (BIT_CLK / 2) @(posedge clk);
		if (!line_rx) begin
			repeat (8) begin
				repeat (BIT_CLK) @(posedge clk);
				sh = {line_rx, sh[7:1]};
			end
			got.push_back(sh);
			repeat (BIT_CLK) @(posedge clk);
		end
	end
endmodule : uc_far_end

// ===== test/uart_tx_rx_status_timing_test.sv
// uart_tx_rx_status_timing_test: self-checking bench of the serial controller
module uart_tx_rx_status_timing_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk, sys_rst, rd_n, wr_n, serial_in, serial_out, cts_n, dsr_n;
	logic       rts_n, dtr_n, clock_out, data_oe, irq_out;
	logic [1:0] addr;
	logic [7:0] data_in, data_out, v, b;
	logic [7:0] rxq[$];
	int         num_errors, tests_run, n;
	time        t0;
	uc_top dut_u (.clk(clk), .sys_rst(sys_rst), .addr(addr), .rd_n(rd_n), .wr_n(wr_n),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe), .irq_out(irq_out),
		.serial_in(serial_in), .serial_out(serial_out), .cts_n(cts_n), .dsr_n(dsr_n),
		.rts_n(rts_n), .dtr_n(dtr_n), .clock_out(clock_out));
	uc_far_end far_u (.clk(clk), .line_rx(serial_out), .line_tx(serial_in));
	initial clk = 1'b0;
	always #50 clk = ~clk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim
	// write strobe held four clocks low, read strobe five, both then four high, over the two-flop sync
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		addr <= a;
		data_in <= d;
		wr_n <= 1'b0;
		repeat (4) @(posedge clk);
		wr_n <= 1'b1;
		t0 = $time;
		repeat (4) @(posedge clk);
	endtask : wr
	task automatic rd(input logic [1:0] a);
		addr <= a;
		rd_n <= 1'b0;
		repeat (4) @(posedge clk);
		@(negedge clk) v = data_out;
		check(data_oe, 1'b1);
		@(posedge clk) rd_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : rd
	task automatic wait_rx(input int k);
		for (int i = 0; i < 3000 && far_u.got.size() < k; i++) @(posedge clk);
	endtask : wait_rx
	task automatic pause(input int k);
		repeat (k) @(posedge clk);
		@(negedge clk);
	endtask : pause
	initial begin
		#3_000_000;
		num_errors++;
		end_sim();
	end
	initial begin
		void'($urandom(13));
		{sys_rst, rd_n, wr_n, cts_n, dsr_n} = 5'h1D;
		addr = 2'h0;
		data_in = 8'h00;
		num_errors = 0;
		tests_run = 0;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		rd(uc_pkg::A_BAUD);
		check(v, uc_pkg::BAUD_RST);
		rd(uc_pkg::A_STAT);
		// clear-to-send low after reset is itself a modem change
		check(v, 8'h50);
		$display("test reset done");
		wr(uc_pkg::A_BAUD, 8'h83);
		n = 0;
		repeat (40) @(negedge clk) n += int'(!clock_out);
		check(n, 10);
		@(posedge clk);
		wr(uc_pkg::A_BAUD, 8'h00);
		n = 0;
		repeat (40) @(negedge clk) n += int'(!clock_out);
		check(n, 20);
		@(posedge clk);
		$display("test clock out done");
		b = 8'($urandom);
		wr(uc_pkg::A_DATA, b);
		n = int'(t0 / 100);
		pause(20);
		@(posedge clk);
		v = 8'($urandom);
		wr(uc_pkg::A_DATA, v);
		rd(uc_pkg::A_STAT);
		check(v[6], 1'b0);
		wait_rx(1);
		check(int'(far_u.t_start / 100) - n inside {[7:9]}, 1);
		t0 = far_u.t_start;
		check(far_u.got.pop_front(), b);
		wait_rx(1);
		check((far_u.t_start - t0) / 100, 160);
		check(far_u.got.size(), 1);
		pause(20);
		@(posedge clk);
		rd(uc_pkg::A_STAT);
		check(v, 8'h60);
		$display("test chained send done");
		far_u.got.delete();
		wr(uc_pkg::A_CTRL, 8'h0D);
		pause(0);
		check({rts_n, dtr_n}, 2'b00);
		@(posedge clk);
		cts_n <= 1'b1;
		pause(8);
		@(posedge clk);
		b = 8'($urandom);
		wr(uc_pkg::A_DATA, b);
		pause(300);
		check(far_u.got.size(), 0);
		@(posedge clk);
		rd(uc_pkg::A_STAT);
		check(v, 8'h10);
		cts_n <= 1'b0;
		wait_rx(1);
		check(far_u.got.pop_front(), b);
		pause(20);
		check(irq_out, 1'b1);
		@(posedge clk);
		rd(uc_pkg::A_STAT);
		check(v, 8'h70);
		check(irq_out, 1'b0);
		$display("test clear to send done");
		wr(uc_pkg::A_CTRL, 8'h03);
		pause(0);
		check({rts_n, dtr_n}, 2'b11);
		@(posedge clk);
		dsr_n <= 1'b0;
		pause(5);
		check(irq_out, 1'b1);
		@(posedge clk);
		rd(uc_pkg::A_STAT);
		check(v, 8'h50);
		check(irq_out, 1'b0);
		wr(uc_pkg::A_CTRL, 8'h01);
		dsr_n <= 1'b1;
		pause(5);
		check(irq_out, 1'b0);
		@(posedge clk);
		rd(uc_pkg::A_STAT);
		check(v, 8'h50);
		$display("test modem change done");
		// nine frames unread: the eighth fills the fifo, the ninth overruns
		for (int i = 0; i < 9; i++) begin
			b = 8'($urandom);
			rxq.push_back(b);
			far_u.send(b);
		end
		pause(20);
		@(posedge clk);
		rd(uc_pkg::A_STAT);
		check(v, 8'hC8);
		for (int i = 0; i < 8; i++) begin
			rd(uc_pkg::A_DATA);
			check(v, rxq.pop_front());
		end
		rd(uc_pkg::A_STAT);
		check(v, 8'h40);
		$display("test receive done");
		end_sim();
	end
endmodule : uart_tx_rx_status_timing_test
